/* svs_fifo.sv */
// synchronous flip-flop fifo with valid/ready on both sides
// assumes one clock; flush and clock enable come from the owner
`timescale 1ns/1ps
module svs_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	input wire logic clk,  // dot clock
	input wire logic rst,  // async reset, active high
	input wire logic ce,  // clock enable
	input wire logic flush,  // synchronous empty
	input wire logic in_valid,  // write request
	output logic in_ready,  // room for one word
	input wire logic [WIDTH-1:0] in_data,  // write word
	output logic out_valid,  // word available
	input wire logic out_ready,  // reader takes word
	output logic [WIDTH-1:0] out_data  // head word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
	} svs_fifo_t;

	svs_fifo_t s;
	svs_fifo_t next_s;
	logic push;
	logic pop;

	// honest flags straight from the occupancy count
	assign in_ready = (s.cnt != FULL_CNT);
	assign out_valid = (s.cnt != '0);
	assign out_data = s.mem[s.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and count update, flush wins over traffic
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr = (s.wr == LAST_PTR) ? '0 : s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = (s.rd == LAST_PTR) ? '0 : s.rd + 1'b1;
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - 1'b1;
		end
		if (flush) begin
			next_s.wr = '0;
			next_s.rd = '0;
			next_s.cnt = '0;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule

/* svs_pkg.sv */
// constants and types shared by the slow video serializer files
// assumes one dot clock domain; all pins sampled synchronously to it
package svs_pkg;
	localparam int SVS_NIB_W = 4;  // nibble bus width, one vram serial port
	localparam int SVS_CHIPS = 4;  // vram devices per bit plane
	localparam int SVS_FIFO_DEPTH = 8;  // nibble fifo depth
	localparam int SVS_CLK_NS = 40;  // dot clock period
	localparam int SVS_STROBE_NS = 40;  // source output delay plus register setup
	// least time, rounded up, never below one cycle
	localparam int SVS_STROBE_RAW = (SVS_STROBE_NS + SVS_CLK_NS - 1) / SVS_CLK_NS;
	localparam int SVS_STROBE_CYC = (SVS_STROBE_RAW < 1) ? 1 : SVS_STROBE_RAW;
	localparam logic [7:0] SVS_STROBE_CNT = 8'(SVS_STROBE_CYC);
	localparam logic [7:0] SVS_DLY_FIRE = 8'h01;  // count value that fires the strobe
	localparam logic [1:0] SVS_DOT_RST = 2'h0;  // dot counter after reset
	localparam logic [1:0] SVS_DOT_TC = 2'h3;  // dot counter terminal count
	localparam logic [1:0] SVS_SEL_RST = 2'h0;  // first vram of the plane
	localparam logic [3:0] SVS_SHREG_RST = 4'h0;  // shifter cleared value
	localparam logic [3:0] SVS_OE_OFF = 4'hF;  // all serial outputs disabled
	// line sequencer, gray along blank -> prime -> active
	typedef enum logic [1:0] {
		SVS_BLANK = 2'b00,
		SVS_PRIME = 2'b01,
		SVS_ACTIVE = 2'b11
	} svs_line_t;
endpackage

/* svs_serializer.sv */
// slow video serializer and monitor-control resynchronizer
// assumes MCLK is the dot clock; all inputs synchronous to it
//
// Functional notes
// - raw blank, hsync and vsync are resampled on the dot clock before use
// - sampling point sits a fixed delay after each word clock rise, every line
// - resample strobe follows word clock rise by output delay plus setup
// - syncs go out through one register, optionally inverted, plus a composite for green
// - this logic fills the assembly fifo from the vram nibble bus at terminal count and drains it
// - display words are 16 bits, four 4-bit vram chips per plane
// - vram serial outputs are enabled one at a time onto the nibble bus
// - nibble feeds a 4-bit parallel-in serial-out shifter with sync reset
// - shifter loads every four dots and shifts one bit per dot between
// - video output is held at zero from one dot after resampled blank goes active
// - select counter picks the vram, stepped at dot terminal count; nibble settles before fourth edge on
`timescale 1ns/1ps
module svs_serializer
	import svs_pkg::*;
#(
	parameter logic SYNC_INVERT = 1'b0,  // invert hsync and vsync outputs
	parameter int FIFO_DEPTH = SVS_FIFO_DEPTH  // nibble fifo depth
) (
	input wire logic MCLK,  // dot clock
	input wire logic RST,  // async reset, active high
	input wire logic CE,  // clock enable, freezes all state
	input wire logic WORD_RATE_VIDEO_CLOCK,  // word-rate video clock, sampled
	input wire logic BLANK_IN,  // raw blank from source, high = blank
	input wire logic HSYNC_IN,  // raw horizontal sync
	input wire logic VSYNC_IN,  // raw vertical sync
	input wire logic [SVS_NIB_W-1:0] NIBBLE_IN,  // shared vram serial nibble bus
	output logic [SVS_CHIPS-1:0] SOE_N,  // vram serial output enables, low active
	output logic VIDEO_OUT,  // serial pixel stream
	output logic HSYNC_OUT,  // resampled horizontal sync
	output logic VSYNC_OUT,  // resampled vertical sync
	output logic CSYNC_OUT,  // composite sync for the green channel
	output logic LOAD_OUT  // shifter load strobe
);
	typedef struct packed {
		logic wclk_q;
		logic [7:0] dly;
		logic blank_s;
		logic hsync_s;
		logic vsync_s;
		svs_line_t line;
		logic [1:0] dot;
		logic [1:0] sel;
		logic [SVS_NIB_W-1:0] shreg;
		logic video;
		logic hs_out;
		logic vs_out;
		logic cs_out;
	} svs_state_t;

	svs_state_t s;
	svs_state_t next_s;
	logic word_rise;
	logic strobe;
	logic tc;
	logic wr_valid;
	logic wr_ready;
	logic rd_valid;
	logic load;
	logic [SVS_NIB_W-1:0] rd_data;

	// nibble buffer between vram bus capture and the shifter
	svs_fifo #(
		.WIDTH(SVS_NIB_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(MCLK),
		.rst(RST),
		.ce(CE),
		.flush(s.blank_s),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(NIBBLE_IN),
		.out_valid(rd_valid),
		.out_ready(load),
		.out_data(rd_data)
	);

	// strobe timing and capture conditions
	assign word_rise = WORD_RATE_VIDEO_CLOCK && !s.wclk_q;
	assign strobe = (s.dly == SVS_DLY_FIRE);
	assign tc = (s.dot == SVS_DOT_TC);
	assign wr_valid = (s.line != SVS_BLANK) && !s.blank_s && tc;
	assign load = (s.line == SVS_ACTIVE) && !s.blank_s && tc;

	// one-hot enable decode of the selected vram
	always_comb begin
		if (s.line == SVS_BLANK) begin
			SOE_N = SVS_OE_OFF;
		end else begin
			SOE_N = ~(SVS_CHIPS'(1) << s.sel);
		end
	end

	assign VIDEO_OUT = s.video;
	assign HSYNC_OUT = s.hs_out;
	assign VSYNC_OUT = s.vs_out;
	assign CSYNC_OUT = s.cs_out;
	assign LOAD_OUT = load;

	// next-state logic for the whole block
	always_comb begin
		next_s = s;
		next_s.wclk_q = WORD_RATE_VIDEO_CLOCK;
		// fixed delay after each word clock rise
		if (word_rise) begin
			next_s.dly = SVS_STROBE_CNT;
		end else if (s.dly != 8'h00) begin
			next_s.dly = s.dly - 8'h01;
		end
		// resample monitor controls on the strobe only
		if (strobe) begin
			next_s.blank_s = BLANK_IN;
			next_s.hsync_s = HSYNC_IN;
			next_s.vsync_s = VSYNC_IN;
		end
		// sync outputs, buffered, hsync and vsync with optional inversion, composite never inverted
		next_s.hs_out = s.hsync_s ^ SYNC_INVERT;
		next_s.vs_out = s.vsync_s ^ SYNC_INVERT;
		next_s.cs_out = s.hsync_s | s.vsync_s;
		// line sequencer
		case (s.line)
			SVS_BLANK: begin
				next_s.dot = SVS_DOT_RST;
				next_s.sel = SVS_SEL_RST;
				if (!s.blank_s) begin
					next_s.line = SVS_PRIME;
				end
			end
			SVS_PRIME: begin
				next_s.dot = s.dot + 2'h1;
				if (wr_valid && wr_ready) begin
					next_s.line = SVS_ACTIVE;
				end
			end
			SVS_ACTIVE: begin
				next_s.dot = s.dot + 2'h1;
			end
			default: begin
				next_s.line = SVS_BLANK;
			end
		endcase
		// next vram only after its nibble was taken, full fifo stalls
		if (wr_valid && wr_ready) begin
			next_s.sel = s.sel + 2'h1;
		end
		if (s.blank_s && s.line != SVS_BLANK) begin
			next_s.line = SVS_BLANK;
		end
		// shifter: sync clear in blank, load each fourth dot, else shift
		if (s.blank_s) begin
			next_s.shreg = SVS_SHREG_RST;
		end else if (load) begin
			next_s.shreg = rd_valid ? rd_data : SVS_SHREG_RST;
		end else begin
			next_s.shreg = {s.shreg[SVS_NIB_W-2:0], 1'b0};
		end
		next_s.video = s.blank_s ? 1'b0 : s.shreg[SVS_NIB_W-1];
	end

	// state register, blank asserted out of reset
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			s <= '0;
			s.blank_s <= 1'b1;
			s.hs_out <= SYNC_INVERT;  // idle sync level, no false pulse out of reset
			s.vs_out <= SYNC_INVERT;
		end else if (CE) begin
			s <= next_s;
		end
	end

	// checks
	a_blank_zero_video: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(CE && s.blank_s) |=> !VIDEO_OUT)
		else $error("video not zero during blank");
	a_oe_one_hot: assert property (@(posedge MCLK) disable iff (RST)
		(s.line != SVS_BLANK) |-> $onehot(~SOE_N))
		else $error("vram enables not one-hot");
	a_load_every_four: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(CE && load) |=> !load [*3] ##1 (load || s.blank_s || (s.line != SVS_ACTIVE)))
		else $error("load not every fourth dot");
	a_load_at_tc: assert property (@(posedge MCLK) disable iff (RST)
		load |-> (s.dot == SVS_DOT_TC) && (s.line == SVS_ACTIVE))
		else $error("load off terminal count");
	a_strobe_after_edge: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(strobe && CE && $past(CE)) |-> $past(word_rise, SVS_STROBE_CYC))
		else $error("strobe not at fixed delay after word clock");
	a_sync_sample_hold: assert property (@(posedge MCLK) disable iff (RST || !CE)
		!strobe |=> $stable(s.hsync_s) && $stable(s.blank_s))
		else $error("controls changed outside strobe");
	a_shift_one_bit: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(CE && !load && !s.blank_s) |=> s.shreg == {$past(s.shreg[SVS_NIB_W-2:0]), 1'b0})
		else $error("shifter did not shift one bit");
	a_sel_at_tc: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(s.line != SVS_BLANK) && !tc |=> $stable(s.sel))
		else $error("vram select moved mid nibble");
	a_full_stalls: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(wr_valid && !wr_ready && !s.blank_s) |=> $stable(s.sel))
		else $error("select advanced into full fifo");
	// frozen cycles are kept out of both antecedent cycles by the sampled enable
	a_video_from_load: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(CE && load && rd_valid) ##1 (CE && !s.blank_s) |=> VIDEO_OUT == $past(rd_data[SVS_NIB_W-1], 2))
		else $error("loaded msb not on video two dots later");
	a_line_first_chip: assert property (@(posedge MCLK) disable iff (RST || !CE)
		(CE && (s.line == SVS_BLANK) && !s.blank_s) |=> (SOE_N == ~(SVS_CHIPS'(1))))
		else $error("line did not start on first vram");
	a_blank_oe_off: assert property (@(posedge MCLK) disable iff (RST)
		(s.line == SVS_BLANK) |-> (SOE_N == SVS_OE_OFF))
		else $error("vram enabled during blank state");
	c_line_start: cover property (@(posedge MCLK) disable iff (RST)
		s.line == SVS_PRIME ##1 s.line == SVS_ACTIVE);
	c_load_data: cover property (@(posedge MCLK) disable iff (RST)
		load && rd_valid);
	c_fifo_full: cover property (@(posedge MCLK) disable iff (RST)
		wr_valid && !wr_ready);
	c_sync_pulse: cover property (@(posedge MCLK) disable iff (RST)
		$rose(HSYNC_OUT ^ SYNC_INVERT));
endmodule

/* svs_src_model.sv */
// source and vram chip model for the serializer bench
// assumes MCLK dot clock; blank and sync levels requested by the bench
`timescale 1ns/1ps
module svs_src_model
	import svs_pkg::*;
(
	input wire logic clk, // dot clock
	input wire logic rst, // async reset
	input wire logic blank_req, // wanted blank level
	input wire logic hs_req, // wanted hsync level
	input wire logic vs_req, // wanted vsync level
	input wire logic [3:0] soe_n, // serial enables, low active
	output logic wclk, // word-rate clock
	output logic blank, // blank to the block
	output logic hs, // hsync to the block
	output logic vs, // vsync to the block
	output logic [3:0] nib // shared nibble bus
);
	logic [2:0] cnt;
	logic [3:0] prev;
	logic [3:0] last;
	logic [1:0] ptr [4];
	// word clock high for four dots, low for four
	assign wclk = ~cnt[2];
	// enabled chip drives; an idle bus shows junk, not the last value
	always_comb begin
		nib = ~last;
		for (int c = 0; c < 4; c++) begin
			if (!soe_n[c]) begin
				nib = {ptr[c], 2'(c)} ^ 4'h9;
			end
		end
	end
	// levels change on word clock rise; chip advances when released
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			blank <= 1'h1;
			hs <= 1'h0;
			vs <= 1'h0;
			prev <= 4'hF;
			last <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				ptr[i] <= 2'h0;
			end
		end else begin
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7) begin
				blank <= blank_req;
				hs <= hs_req;
				vs <= vs_req;
			end
			prev <= soe_n;
			last <= nib;
			for (int i = 0; i < 4; i++) begin
				if (!prev[i] && soe_n[i]) begin
					ptr[i] <= ptr[i] + 2'h1;
				end
			end
		end
	end
endmodule

/* tb_svs_serializer.sv */
// self-checking bench for the slow video serializer
// assumes svs_src_model stands in for the source and vram chips
`timescale 1ns/1ps
module tb_svs_serializer
	import svs_pkg::*;
;
	typedef struct packed {logic hs; logic vs; logic [2:0] exp; logic [2:0] inv;} svs_row_t;
	svs_row_t rows [4] = '{'{1'h0, 1'h0, 3'h0, 3'h6}, '{1'h1, 1'h0, 3'h5, 3'h3},
		'{1'h0, 1'h1, 3'h3, 3'h5}, '{1'h1, 1'h1, 3'h7, 3'h1}};
	logic mclk, rst, ce, blank_req, hs_req, vs_req;
	logic wclk, blank, hs, vs, video, hso, vso, cso, load;
	logic [3:0] nib, soe_n, nb;
	logic hso_i, vso_i, cso_i;
	logic [3:0] fz_oe, fz_out;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	int n, nl;
	svs_src_model i_src (.clk(mclk), .rst(rst), .blank_req(blank_req),
		.hs_req(hs_req), .vs_req(vs_req), .soe_n(soe_n), .wclk(wclk),
		.blank(blank), .hs(hs), .vs(vs), .nib(nib));
	svs_serializer i_dut (.MCLK(mclk), .RST(rst), .CE(ce),
		.WORD_RATE_VIDEO_CLOCK(wclk), .BLANK_IN(blank), .HSYNC_IN(hs),
		.VSYNC_IN(vs), .NIBBLE_IN(nib), .SOE_N(soe_n), .VIDEO_OUT(video),
		.HSYNC_OUT(hso), .VSYNC_OUT(vso), .CSYNC_OUT(cso), .LOAD_OUT(load));
	// second copy with inverted syncs, fed the same inputs
	svs_serializer #(.SYNC_INVERT(1'b1)) i_dut_inv (.MCLK(mclk), .RST(rst), .CE(ce),
		.WORD_RATE_VIDEO_CLOCK(wclk), .BLANK_IN(blank), .HSYNC_IN(hs),
		.VSYNC_IN(vs), .NIBBLE_IN(nib), .SOE_N(), .VIDEO_OUT(),
		.HSYNC_OUT(hso_i), .VSYNC_OUT(vso_i), .CSYNC_OUT(cso_i), .LOAD_OUT());
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end
	// watchdog on the whole run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		rst = 1'h1;
		ce = 1'h1;
		blank_req = 1'h1;
		hs_req = 1'h0;
		vs_req = 1'h0;
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		@(negedge mclk);
		chk(soe_n, SVS_OE_OFF);
		chk({load, video, cso, hso}, 4'h0);
		chk({1'h0, hso_i, vso_i, cso_i}, 4'h6);
		// sync rows, each resampled on the word clock
		foreach (rows[r]) begin
			@(posedge mclk);
			hs_req <= rows[r].hs;
			vs_req <= rows[r].vs;
			repeat (24) @(negedge mclk);
			chk({1'h0, hso, vso, cso}, {1'h0, rows[r].exp});
			chk({1'h0, hso_i, vso_i, cso_i}, {1'h0, rows[r].inv});
		end
		// active line: four chips in turn, msb first
		@(posedge mclk);
		blank_req <= 1'h0;
		n = 0;
		while (load !== 1'h1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		chk({3'h0, load}, 4'h1);
		@(negedge mclk);
		nl = 0;
		for (int i = 0; i < 32; i++) begin
			@(negedge mclk);
			nb = {2'(i / 16), 2'(i / 4)} ^ 4'h9;
			chk({3'h0, video}, {3'h0, nb[3 - i % 4]});
			chk(4'($countones(~soe_n)), 4'h1);
			nl += (load === 1'h1) ? 1 : 0;
		end
		chk(4'(nl), 4'h8);
		// clock enable low: enables, load, video, hsync and csync stand still, then the dots resume
		@(posedge mclk);
		ce <= 1'h0;
		@(negedge mclk);
		fz_oe = soe_n;
		fz_out = {load, video, hso, cso};
		repeat (6) begin
			@(negedge mclk);
			chk(soe_n, fz_oe);
			chk({load, video, hso, cso}, fz_out);
		end
		@(posedge mclk);
		ce <= 1'h1;
		@(negedge mclk);
		nl = 0;
		for (int i = 0; i < 16; i++) begin
			@(negedge mclk);
			nl += (load === 1'h1) ? 1 : 0;
		end
		chk(4'(nl), 4'h4);
		// blank again: output forced low, all chips off
		@(posedge mclk);
		blank_req <= 1'h1;
		repeat (24) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk);
			chk({load, video, 2'h0}, 4'h0);
			chk(soe_n, SVS_OE_OFF);
		end
		// reset in mid-line clears the output at once
		@(posedge mclk);
		blank_req <= 1'h0;
		repeat (30) @(posedge mclk);
		rst <= 1'h1;
		@(negedge mclk);
		chk({load, video, cso, 1'h0}, 4'h0);
		chk(soe_n, SVS_OE_OFF);
		@(posedge mclk);
		rst <= 1'h0;
		// first two edges after release: still blank, syncs idle
		repeat (2) begin
			@(negedge mclk);
			chk(soe_n, SVS_OE_OFF);
			chk({load, video, cso, hso}, 4'h0);
			chk({1'h0, hso_i, vso_i, cso_i}, 4'h6);
		end
		stop_test();
	end
endmodule
